/* src/dsc_alu.sv */
// Operand-selection and arithmetic datapath with an AHB-Lite register window.
//
// Summary of operation
// - sixteen working registers usable as any operand except multiply and square operands, which are 4-7 only.
// - file add-with-carry uses register 0 as second operand.
// - square takes only equal pairs of registers 4-7.
// - multiply takes only six distinct pairs 4-7.
// - divide reads a register pair, direct only.
// - X pointer 8 or 9, adjust, index, none.
// - Y pointer 10 or 11, adjust, index, none.
// - prefetched data lands only in registers 4-7.
// - signed shifted add to accumulator, accumulator flags.
// - file add-with-carry into file or register 0, five flags.
// - literal add-with-carry back into named register.
// - base plus short literal plus carry to destination.
// - file shift right one, sign kept, four flags.
// - register shift right one keeping sign bit.
// - shift by register count, only negative and zero.
// - shift by short literal, only negative and zero.
// - word with zero top byte runs as no-operation.
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module dsc_alu
  import dsc_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Decoded instruction.
  input wire logic op_valid,
  input wire logic [7:0] op_top8,
  input wire dsc_op_t op_code,
  input wire logic [3:0] base_reg,
  input wire logic [3:0] src_sel,
  input wire logic [3:0] dest_operand,
  input wire logic [12:0] file_addr,
  input wire logic to_default_work_reg,
  input wire logic [9:0] medium_literal,
  input wire logic [4:0] short_literal,
  input wire logic [3:0] signed_shift_literal,
  input wire logic acc_sel,
  input wire logic [1:0] mul_m,
  input wire logic [1:0] mul_n,
  input wire dsc_pf_t x_prefetch_ptr,
  input wire logic [2:0] x_adjust,
  input wire logic [1:0] x_dest,
  input wire dsc_pf_t y_prefetch_ptr,
  input wire logic [2:0] y_adjust,
  input wire logic [1:0] y_dest,
  // Results.
  output logic [8:0] status_flags,
  output logic op_done,
  output logic op_illegal
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Maps a byte address onto a data memory word.
  function automatic logic [4:0] mem_index(input logic [15:0] byte_addr);
    mem_index = byte_addr[5:1];
  endfunction : mem_index

  // Effective address of a prefetch; the index form adds the shared index.
  function automatic logic [15:0] pf_addr(input dsc_pf_t mode, input logic [15:0] lo,
                                          input logic [15:0] hi, input logic [15:0] idx);
    case (mode)
      PF_LOW: pf_addr = lo;
      PF_HIGH: pf_addr = hi;
      PF_INDEX: pf_addr = 16'(hi + idx);
      default: pf_addr = 16'h0000;
    endcase
  endfunction : pf_addr

  // Post-adjust in bytes: the 3-bit code counts words, so -6..+6 in steps of 2.
  function automatic logic [15:0] adj_bytes(input logic [2:0] code);
    adj_bytes = {{12{code[2]}}, code, 1'b0};
  endfunction : adj_bytes

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [15:0] default_work_reg [NUM_DEFAULT_WORK_REG];     // Working registers.
  logic [15:0] mem [MEM_WORDS];     // File registers and prefetch space.
  logic [39:0] acc [NUM_ACC];       // Accumulators.
  logic dph_we;                     // Bus data phase carries a write.
  logic [7:0] dph_addr;             // Bus data phase address.

  // ****************************************************************
  // Decode and legality.
  // ****************************************************************
  logic exec;        // Instruction present and not a stray second word.
  logic illegal;     // Operand choice outside the allowed sets.
  logic run;         // Instruction actually executes this cycle.
  logic pf_op;       // Operation carries X/Y prefetches.

  // A stray second word has a zero top byte and must do nothing.
  assign exec = op_valid && (op_top8 != LONE_TOP8) && (op_code != OP_NOP);
  assign pf_op = (op_code == OP_MAC) || (op_code == OP_SQR);
  // Square allows only a register times itself, multiply only distinct pairs.
  assign illegal = exec && (((op_code == OP_SQR) && (mul_m != mul_n)) ||
                            ((op_code == OP_MAC) && (mul_m >= mul_n)) ||
                            (pf_op && (x_adjust == ADJ_RESERVED)) ||
                            (pf_op && (y_adjust == ADJ_RESERVED)));
  assign run = exec && !illegal;

  // ****************************************************************
  // Arithmetic: add-with-carry and shifts.
  // ****************************************************************
  logic [15:0] fval, opa, opb, shv, res;
  logic [16:0] sum;
  logic [4:0] nib, shc;
  logic [15:0] shres;
  logic w_we, m_we;
  logic [3:0] w_idx;
  logic [8:0] f_mask, f_val;

  // Chooses operands and shift count; forms the carry sum, half-carry and shift result.
  always_comb begin
    fval = mem[mem_index({3'b000, file_addr})];
    opa = 16'h0000;
    opb = 16'h0000;
    shv = 16'h0000;
    shc = 5'h00;
    case (op_code)
      OP_ADD_WITH_CARRY_F: begin
        opa = fval;
        opb = default_work_reg[DEFAULT_WORK_REG_IDX];
      end
      OP_ADD_WITH_CARRY_MEDIUM_LITERAL: begin
        opa = default_work_reg[dest_operand];
        opb = {6'h00, medium_literal};
      end
      OP_ADD_WITH_CARRY_WS: begin
        opa = default_work_reg[base_reg];
        opb = default_work_reg[src_sel];
      end
      OP_ADD_WITH_CARRY_SHORT_LITERAL: begin
        opa = default_work_reg[base_reg];
        opb = {11'h000, short_literal};
      end
      OP_ASR_F: begin
        shv = fval;
        shc = 5'h01;
      end
      OP_ASR_WS: begin
        shv = default_work_reg[src_sel];
        shc = 5'h01;
      end
      OP_ASR_REG: begin
        shv = default_work_reg[base_reg];
        shc = {1'b0, default_work_reg[src_sel][3:0]};
      end
      OP_ASR_SHORT_LITERAL: begin
        shv = default_work_reg[base_reg];
        shc = short_literal;
      end
      default: begin
        opa = 16'h0000;
      end
    endcase
    sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, status_flags[F_C]};
    nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, status_flags[F_C]};
    shres = 16'($signed(shv) >>> shc);
  end

  // Write target and flag mask per operation; unlisted flags stay masked off.
  always_comb begin
    w_we = 1'b0;
    m_we = 1'b0;
    w_idx = dest_operand;
    res = sum[15:0];
    f_mask = 9'h000;
    f_val = 9'h000;
    case (op_code)
      OP_ADD_WITH_CARRY_F, OP_ADD_WITH_CARRY_MEDIUM_LITERAL, OP_ADD_WITH_CARRY_WS, OP_ADD_WITH_CARRY_SHORT_LITERAL: begin
        // File form goes to the file or to the default register.
        m_we = (op_code == OP_ADD_WITH_CARRY_F) && !to_default_work_reg;
        w_we = !m_we;
        w_idx = (op_code == OP_ADD_WITH_CARRY_F) ? DEFAULT_WORK_REG_IDX : dest_operand;
        f_mask = 9'h01F;
        f_val[F_C] = sum[16];
        f_val[F_DC] = nib[4];
        f_val[F_N] = sum[15];
        f_val[F_OV] = (opa[15] == opb[15]) && (sum[15] != opa[15]);
        // Zero is sticky for carry chains: it can only be cleared.
        f_val[F_Z] = status_flags[F_Z] && (sum[15:0] == 16'h0000);
      end
      OP_ASR_F, OP_ASR_WS: begin
        m_we = (op_code == OP_ASR_F) && !to_default_work_reg;
        w_we = !m_we;
        w_idx = (op_code == OP_ASR_F) ? DEFAULT_WORK_REG_IDX : dest_operand;
        res = shres;
        f_mask = 9'h00F;
        f_val[F_C] = shv[0];
        f_val[F_N] = shres[15];
        f_val[F_OV] = 1'b0;
        f_val[F_Z] = (shres == 16'h0000);
      end
      OP_ASR_REG, OP_ASR_SHORT_LITERAL: begin
        w_we = 1'b1;
        res = shres;
        f_mask = 9'h00A;
        f_val[F_N] = shres[15];
        f_val[F_Z] = (shres == 16'h0000);
      end
      default: begin
        w_we = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Accumulator arithmetic.
  // ****************************************************************
  logic [39:0] acc_cur, addend, acc_new, src_ext;
  logic [15:0] mul_a, mul_b;
  logic [31:0] prod;
  logic acc_oa, acc_sa;

  // The signed source sits in bits 31:16; a negative literal shifts left.
  always_comb begin
    acc_cur = acc[acc_sel];
    src_ext = {{8{default_work_reg[src_sel][15]}}, default_work_reg[src_sel], 16'h0000};
    mul_a = default_work_reg[MUL_BASE + {2'b00, mul_m}];
    mul_b = default_work_reg[MUL_BASE + {2'b00, mul_n}];
    prod = 32'($signed(mul_a) * $signed(mul_b));
    if (op_code == OP_ADD_ACC) begin
      if (signed_shift_literal[3]) begin
        // Magnitude of a negative count, kept at four bits so -8 stays 8.
        addend = src_ext << 4'(-signed_shift_literal);
      end else begin
        addend = 40'($signed(src_ext) >>> signed_shift_literal);
      end
    end else begin
      addend = {{8{prod[31]}}, prod};
    end
    acc_new = 40'(acc_cur + addend);
    // Guard-bit overflow and loss of the 40-bit sign.
    acc_oa = !((acc_new[39:31] == 9'h000) || (acc_new[39:31] == 9'h1FF));
    acc_sa = (acc_cur[39] == addend[39]) && (acc_new[39] != acc_cur[39]);
  end

  // Accumulators; only the chosen one changes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc[0] <= 40'h00_0000_0000;
      acc[1] <= 40'h00_0000_0000;
    end else if (run && ((op_code == OP_ADD_ACC) || pf_op)) begin
      acc[acc_sel] <= acc_new;
    end
  end

  // Status flags: masked update; the sticky saturation bit only sets.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_flags <= FLAGS_RST;
    end else if (run && (op_code == OP_ADD_ACC)) begin
      status_flags[acc_sel ? F_OB : F_OA] <= acc_oa;
      status_flags[acc_sel ? F_SB : F_SA] <= status_flags[acc_sel ? F_SB : F_SA] | acc_sa;
    end else if (run) begin
      status_flags <= (status_flags & ~f_mask) | (f_val & f_mask);
    end
  end

  // ****************************************************************
  // Working registers, prefetches and divide.
  // ****************************************************************
  logic [15:0] xa, ya;
  assign xa = pf_addr(x_prefetch_ptr, default_work_reg[X_LOW_IDX], default_work_reg[X_HIGH_IDX], default_work_reg[INDEX_IDX]);
  assign ya = pf_addr(y_prefetch_ptr, default_work_reg[Y_LOW_IDX], default_work_reg[Y_HIGH_IDX], default_work_reg[INDEX_IDX]);

  // Later assignments win: bus write, pointer adjust, prefetch, then result.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_DEFAULT_WORK_REG; i++) begin
        default_work_reg[i] <= 16'h0000;
      end
    end else begin
      if (dph_we && (dph_addr[7:6] == DEFAULT_WORK_REG_PAGE)) begin
        default_work_reg[dph_addr[5:2]] <= hwdata[15:0];
      end
      if (run && pf_op) begin
        // Post-adjust only for the plain pointer forms, never the index form.
        if (x_prefetch_ptr == PF_LOW) default_work_reg[X_LOW_IDX] <= 16'(xa + adj_bytes(x_adjust));
        if (x_prefetch_ptr == PF_HIGH) default_work_reg[X_HIGH_IDX] <= 16'(xa + adj_bytes(x_adjust));
        if (y_prefetch_ptr == PF_LOW) default_work_reg[Y_LOW_IDX] <= 16'(ya + adj_bytes(y_adjust));
        if (y_prefetch_ptr == PF_HIGH) default_work_reg[Y_HIGH_IDX] <= 16'(ya + adj_bytes(y_adjust));
        if (x_prefetch_ptr != PF_NONE) begin
          default_work_reg[MUL_BASE + {2'b00, x_dest}] <= mem[mem_index(xa)];
        end
        if (y_prefetch_ptr != PF_NONE) begin
          default_work_reg[MUL_BASE + {2'b00, y_dest}] <= mem[mem_index(ya)];
        end
      end
      // Divide uses plain register contents; a zero divisor leaves all alone.
      if (run && (op_code == OP_DIV) && (default_work_reg[src_sel] != 16'h0000)) begin
        default_work_reg[QUOT_IDX] <= default_work_reg[base_reg] / default_work_reg[src_sel];
        default_work_reg[REM_IDX] <= default_work_reg[base_reg] % default_work_reg[src_sel];
      end
      if (run && w_we) begin
        default_work_reg[w_idx] <= res;
      end
    end
  end

  // Data memory: written by file forms and by the bus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= 16'h0000;
      end
    end else begin
      if (dph_we && (dph_addr[7] == MEM_PAGE)) begin
        mem[dph_addr[6:2]] <= hwdata[15:0];
      end
      if (run && m_we) begin
        mem[mem_index({3'b000, file_addr})] <= res;
      end
    end
  end

  // One-cycle completion and refusal pulses.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_done <= 1'b0;
      op_illegal <= 1'b0;
    end else begin
      op_done <= run;
      op_illegal <= illegal;
    end
  end

  // ****************************************************************
  // AHB-Lite slave: zero wait states, always OKAY.
  // ****************************************************************
  logic addr_ok, take;
  logic [31:0] rd_val;
  assign addr_ok = (haddr[31:8] == 24'h00_0000);
  assign take = hsel && hready && htrans[1] && addr_ok;

  // Read mux; unmapped words read as zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[7] == MEM_PAGE) begin
      rd_val = {16'h0000, mem[haddr[6:2]]};
    end else if (haddr[7:6] == DEFAULT_WORK_REG_PAGE) begin
      rd_val = {16'h0000, default_work_reg[haddr[5:2]]};
    end else begin
      case (haddr[7:0])
        ADDR_STATUS: rd_val = {23'h00_0000, status_flags};
        ADDR_ACCA_LO: rd_val = acc[0][31:0];
        ADDR_ACCA_HI: rd_val = {24'h00_0000, acc[0][39:32]};
        ADDR_ACCB_LO: rd_val = acc[1][31:0];
        ADDR_ACCB_HI: rd_val = {24'h00_0000, acc[1][39:32]};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Address phase capture; read data is registered for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_we <= 1'b0;
      dph_addr <= 8'h00;
      hrdata <= RDATA_RST;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      dph_we <= take && hwrite && (hsize == HSIZE_WORD);
      dph_addr <= haddr[7:0];
      hrdata <= (take && !hwrite) ? rd_val : RDATA_RST;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence lone_word_s;
    op_valid && (op_top8 == LONE_TOP8);
  endsequence
  sequence asr_count_s;
    run && ((op_code == OP_ASR_REG) || (op_code == OP_ASR_SHORT_LITERAL));
  endsequence
  sequence acc_add_s;
    run && (op_code == OP_ADD_ACC);
  endsequence

  lone_word_nop_a: assert property (lone_word_s |=> !op_done && $stable(status_flags))
    else $error("Stray second word changed state.");
  count_shift_flags_a: assert property (asr_count_s |=> $stable(status_flags[F_C]) && $stable(status_flags[F_OV]))
    else $error("Counted shift changed carry or overflow.");
  acc_add_flags_a: assert property (acc_add_s |=> $stable(status_flags[4:0]))
    else $error("Accumulator add touched core flags.");
  square_pair_a: assert property ((exec && (op_code == OP_SQR) && (mul_m != mul_n)) |=> op_illegal && !op_done)
    else $error("Unequal square pair was accepted.");
  mul_pair_a: assert property ((exec && (op_code == OP_MAC) && (mul_m >= mul_n)) |=> op_illegal && !op_done)
    else $error("Multiply pair outside the six was accepted.");
  file_shift_ov_a: assert property ((run && (op_code == OP_ASR_F)) |=> !status_flags[F_OV] && op_done)
    else $error("File shift left overflow set.");
  sticky_zero_a: assert property ((run && (op_code == OP_ADD_WITH_CARRY_F) && !status_flags[F_Z]) |=> !status_flags[F_Z])
    else $error("Carry add set the zero flag.");
  prefetch_dest_a: assert property ((run && pf_op) |=> $stable(default_work_reg[0]) && $stable(default_work_reg[3]))
    else $error("Prefetch wrote outside registers four to seven.");
  bus_ready_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("Bus slave stalled or errored.");

endmodule : dsc_alu

`default_nettype wire

/* src/dsc_pkg.sv */
// Shared constants and types for the operand-selection and arithmetic datapath.
package dsc_pkg;

  // ****************************************************************
  // Datapath geometry.
  // ****************************************************************
  localparam int unsigned NUM_DEFAULT_WORK_REG = 16;   // Sixteen general working registers.
  localparam int unsigned MEM_WORDS = 32;  // Small data memory for files and prefetch.
  localparam int unsigned NUM_ACC = 2;     // Accumulators A and B.
  localparam int unsigned NUM_FLAGS = 9;   // Width of the status flag vector.

  // ****************************************************************
  // Fixed register roles.
  // ****************************************************************
  localparam logic [3:0] DEFAULT_WORK_REG_IDX = 4'h0;     // Default working register.
  localparam logic [3:0] QUOT_IDX = 4'h0;     // Divide quotient target.
  localparam logic [3:0] REM_IDX = 4'h1;      // Divide remainder target.
  localparam logic [3:0] MUL_BASE = 4'h4;     // First multiplier/prefetch target register.
  localparam logic [3:0] X_LOW_IDX = 4'h8;    // X pointer, low choice.
  localparam logic [3:0] X_HIGH_IDX = 4'h9;   // X pointer, high (indexable) choice.
  localparam logic [3:0] Y_LOW_IDX = 4'hA;    // Y pointer, low choice.
  localparam logic [3:0] Y_HIGH_IDX = 4'hB;   // Y pointer, high (indexable) choice.
  localparam logic [3:0] INDEX_IDX = 4'hC;    // Shared prefetch index register.
  localparam logic [7:0] LONE_TOP8 = 8'h00;   // Top byte of a stray second word.
  localparam logic [2:0] ADJ_RESERVED = 3'h4; // Post-adjust code with no legal meaning.

  // ****************************************************************
  // Status flag positions and reset value.
  // ****************************************************************
  localparam int unsigned F_C = 0;
  localparam int unsigned F_Z = 1;
  localparam int unsigned F_OV = 2;
  localparam int unsigned F_N = 3;
  localparam int unsigned F_DC = 4;
  localparam int unsigned F_OA = 5;
  localparam int unsigned F_OB = 6;
  localparam int unsigned F_SA = 7;
  localparam int unsigned F_SB = 8;
  localparam logic [8:0] FLAGS_RST = 9'h000;

  // ****************************************************************
  // Bus map (byte addresses, low byte of the bus address).
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_ACCA_LO = 8'h44;
  localparam logic [7:0] ADDR_ACCA_HI = 8'h48;
  localparam logic [7:0] ADDR_ACCB_LO = 8'h4C;
  localparam logic [7:0] ADDR_ACCB_HI = 8'h50;
  localparam logic [1:0] DEFAULT_WORK_REG_PAGE = 2'h0;    // Bits 7:6 of working register window.
  localparam logic [0:0] MEM_PAGE = 1'h1;     // Bit 7 of data memory window.
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ****************************************************************
  // Operations and prefetch modes.
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NOP        = 4'b0000,
    OP_ADD_WITH_CARRY_F     = 4'b0001,
    OP_ADD_WITH_CARRY_MEDIUM_LITERAL = 4'b0010,
    OP_ADD_WITH_CARRY_WS    = 4'b0011,
    OP_ADD_WITH_CARRY_SHORT_LITERAL  = 4'b0100,
    OP_ADD_ACC    = 4'b0101,
    OP_ASR_F      = 4'b0110,
    OP_ASR_WS     = 4'b0111,
    OP_ASR_REG    = 4'b1000,
    OP_ASR_SHORT_LITERAL   = 4'b1001,
    OP_MAC        = 4'b1010,
    OP_SQR        = 4'b1011,
    OP_DIV        = 4'b1100
  } dsc_op_t;

  typedef enum logic [1:0] {
    PF_NONE  = 2'b00,
    PF_LOW   = 2'b01,
    PF_HIGH  = 2'b10,
    PF_INDEX = 2'b11
  } dsc_pf_t;

endpackage : dsc_pkg

/* verification/dsc_operand_alu_ops_bench.sv */
// Self-checking testbench for the operand-selection and arithmetic datapath.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %0t: got %h expected %h", $time, g, e); end end

module dsc_operand_alu_ops_bench import dsc_pkg::*; ;
  // Bus side stimulus.
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, op_valid = 0, to_default_work_reg = 0, acc_sel = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, mul_m = 0, mul_n = 0, x_dest = 0, y_dest = 0;
  logic [2:0] hsize = HSIZE_WORD, x_adjust = 0, y_adjust = 0;
  // Instruction side stimulus.
  logic [7:0] op_top8 = 8'h80;
  dsc_op_t op_code = OP_NOP;
  logic [3:0] base_reg = 0, src_sel = 0, dest_operand = 0, signed_shift_literal = 0;
  logic [12:0] file_addr = 0;
  logic [9:0] medium_literal = 0, k, eo;
  logic [4:0] short_literal = 0, j;
  dsc_pf_t x_prefetch_ptr = PF_NONE, y_prefetch_ptr = PF_NONE;
  logic hreadyout, hresp, op_done, op_illegal, rd_dp = 0;
  logic [8:0] status_flags, fl;
  // Reference model state: the bench's own copy of registers, memory and flags.
  logic [15:0] w [16];
  logic [15:0] mem [32];
  logic [15:0] r;
  logic [3:0] bb, ss, dd;
  logic [31:0] er, rq [$];
  logic [9:0] oq [$];
  int errors = 0, cmp_count = 0, seed = 32'h594ab4cb;

  initial forever #10 hclk = ~hclk;

  dsc_alu i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .op_valid, .op_top8, .op_code, .base_reg, .src_sel,
    .dest_operand, .file_addr, .to_default_work_reg, .medium_literal, .short_literal, .signed_shift_literal,
    .acc_sel, .mul_m, .mul_n, .x_prefetch_ptr, .x_adjust, .x_dest, .y_prefetch_ptr, .y_adjust,
    .y_dest, .status_flags, .op_done, .op_illegal);

  // *****************
  // Output watcher: pops the oldest note whenever read data or a pulse shows.
  // *****************
  always @(posedge hclk) begin
    if (rd_dp) begin
      er = rq.pop_front();
      `CHK(hrdata, er)
      `CHK(hresp, 1'b0)
    end
    if (op_done === 1'b1 || op_illegal === 1'b1) begin
      eo = oq.size() ? oq.pop_front() : 10'h3ff; // A pulse nobody asked for must fail.
      `CHK({op_illegal, status_flags}, eo)
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  task automatic final_report();
    $display("counts: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Waits one edge at which ready is seen high; bounded so a stuck slave ends the run.
  task automatic tick();
    int n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin errors++; $display("mismatch %0t: bus hang", $time); final_report(); end
  endtask : tick

  task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] d);
    hsel <= 1; htrans <= 2'b10; hwrite <= wr; haddr <= a;
    tick();
    hsel <= 0; htrans <= 0; hwdata <= {16'h0000, d};
    tick();
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rd

  // One instruction; an edge passes after op_valid drops so it is never driven twice at once.
  task automatic run(input logic [9:0] e, input logic pulse);
    if (pulse) oq.push_back(e);
    op_valid <= 1; @(posedge hclk); op_valid <= 0; @(posedge hclk);
  endtask : run

  function automatic logic [15:0] add_with_carry(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    logic [4:0] h;
    s = a + b + fl[F_C]; h = a[3:0] + b[3:0] + fl[F_C];
    fl[F_DC] = h[4]; fl[F_OV] = (a[15] == b[15]) && (s[15] != a[15]); fl[F_N] = s[15];
    if (s[15:0] != 0) fl[F_Z] = 0; // Zero only ever clears on carry adds.
    fl[F_C] = s[16];
    return s[15:0];
  endfunction : add_with_carry

  function automatic logic [15:0] arith_shift_right(input logic [15:0] a, input int n, input logic all);
    logic [15:0] q;
    q = $signed(a) >>> n;
    if (all) begin fl[F_C] = a[0]; fl[F_OV] = 0; end
    fl[F_N] = q[15]; fl[F_Z] = (q == 0);
    return q;
  endfunction : arith_shift_right

  // *****************
  // Main sequence.
  // *****************
  initial begin
    fl = FLAGS_RST;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    for (int i = 0; i < 16; i++) begin w[i] = $random(seed); bus(1, 4*i, w[i]); end
    for (int i = 0; i < 32; i++) begin mem[i] = $random(seed); bus(1, 128 + 4*i, mem[i]); end
    for (int i = 0; i < 16; i++) rd(4*i, w[i]);
    hsize <= 3'h1; bus(1, 8, 16'h1234); hsize <= HSIZE_WORD;
    rd(8, w[2]); rd(32'h104, 0); rd(32'h40, FLAGS_RST); // Narrow write and stray address refused.
    $display("test registers done");
    // Both families alternate forms; in each group of eight, the first four add and the last four shift.
    for (int i = 0; i < 32; i++) begin
      bb = $random(seed); ss = $random(seed); dd = $random(seed); k = $random(seed);
      j = $random(seed);
      base_reg <= bb; src_sel <= ss; dest_operand <= dd; medium_literal <= k;
      short_literal <= k[4:0]; file_addr <= {7'h00, j, 1'b0}; to_default_work_reg <= i[3];
      case (i % 8)
        0: begin op_code <= OP_ADD_WITH_CARRY_F; r = add_with_carry(mem[j], w[0]); end
        1: begin op_code <= OP_ADD_WITH_CARRY_MEDIUM_LITERAL; w[dd] = add_with_carry(w[dd], {6'h00, k}); end
        2: begin op_code <= OP_ADD_WITH_CARRY_WS; w[dd] = add_with_carry(w[bb], w[ss]); end
        3: begin op_code <= OP_ADD_WITH_CARRY_SHORT_LITERAL; w[dd] = add_with_carry(w[bb], {11'h000, k[4:0]}); end
        4: begin op_code <= OP_ASR_F; r = arith_shift_right(mem[j], 1, 1); end
        5: begin op_code <= OP_ASR_WS; w[dd] = arith_shift_right(w[ss], 1, 1); end
        6: begin op_code <= OP_ASR_REG; w[dd] = arith_shift_right(w[bb], w[ss][3:0], 0); end
        default: begin op_code <= OP_ASR_SHORT_LITERAL; w[dd] = arith_shift_right(w[bb], k[4:0], 0); end
      endcase
      if (i % 4 == 0 && i[3]) w[0] = r;
      else if (i % 4 == 0) mem[j] = r;
      run({1'b0, fl}, 1);
      rd(0, w[0]); rd(4*dd, w[dd]); rd(128 + 4*j, mem[j]);
    end
    $display("test add and shift done");
    op_code <= OP_SQR; mul_m <= 0; mul_n <= 1; run({1'b1, fl}, 1);
    op_code <= OP_MAC; mul_m <= 1; run({1'b1, fl}, 1);
    op_code <= OP_SQR; run({1'b0, fl}, 1);
    op_code <= OP_ADD_WITH_CARRY_MEDIUM_LITERAL; op_top8 <= LONE_TOP8; dest_operand <= 3; run(0, 0);
    op_top8 <= 8'h80; rd(12, w[3]);
    op_code <= OP_DIV; base_reg <= 2; src_sel <= 3; run({1'b0, fl}, 1);
    if (w[3] != 0) begin r = w[2] / w[3]; w[1] = w[2] % w[3]; w[0] = r; end
    rd(0, w[0]); rd(4, w[1]);
    $display("test refusals done");
    bus(1, 32, 16'h0006); bus(1, 36, 16'h0010); bus(1, 48, 16'h0004); bus(1, 44, 16'h0030);
    op_code <= OP_MAC; mul_m <= 0; mul_n <= 1; x_prefetch_ptr <= PF_LOW; x_adjust <= 3'h3;
    x_dest <= 2; y_prefetch_ptr <= PF_HIGH; y_adjust <= 3'h6; y_dest <= 3;
    run({1'b0, fl}, 1);
    rd(24, mem[3]); rd(32, 16'h000c); rd(28, mem[24]); rd(44, 16'h002c);
    x_prefetch_ptr <= PF_INDEX; y_prefetch_ptr <= PF_INDEX; x_dest <= 0; y_dest <= 1;
    run({1'b0, fl}, 1);
    rd(16, mem[10]); rd(20, mem[24]); rd(36, 16'h0010);
    x_prefetch_ptr <= PF_LOW; x_adjust <= ADJ_RESERVED; run({1'b1, fl}, 1);
    rd(32, 16'h000c);
    $display("test prefetch done");
    // Accumulator B is untouched so far; W8 holds 0x000c: left by one, then right by one.
    acc_sel <= 1; src_sel <= 4'h8; signed_shift_literal <= 4'hf; op_code <= OP_ADD_ACC;
    run({1'b0, fl}, 1);
    signed_shift_literal <= 4'h1; run({1'b0, fl}, 1);
    rd(32'h4c, 32'h001e_0000); rd(32'h50, 0);
    $display("test accumulator done");
    repeat (3) @(posedge hclk);
    `CHK(oq.size() + rq.size(), 0)
    final_report();
  end
endmodule : dsc_operand_alu_ops_bench

`default_nettype wire
